// ==== design/port16_consts.svh ====
// register map, field positions, reset values and timing counts
`ifndef PORT16_CONSTS_SVH
`define PORT16_CONSTS_SVH
`define OFS_A_CTRL     5'h00
`define OFS_B_CTRL     5'h04
`define OFS_GEN_CTRL   5'h08
`define OFS_STATUS     5'h0C
`define OFS_DIR        5'h10
`define OFS_DATA_A     5'h14
`define OFS_DATA_B     5'h18
`define CTRL_RESET     8'h00
`define WORD_RESET     16'h0000
`define SUB_BIT        6
`define CODE_HI        5
`define CODE_LO        3
`define SVC_BIT        1
`define STC_BIT        0
`define GEN_A_EN_BIT   0
`define GEN_B_EN_BIT   1
`define ST_A1_BIT      0
`define ST_A2_BIT      1
`define ST_B3_BIT      2
`define ST_B4_BIT      3
`define PULSE_CYCLES   4
`define OUT_DELAY      2'h2
`endif

// ==== design/port16_pkg.sv ====
// shared types of the sixteen-bit handshake port
package port16_pkg;
  // occupancy of a double buffer, gray coded along fill and drain
  typedef enum logic [1:0] {
    buf_empty_type = 2'b00,
    buf_one_type   = 2'b01,
    buf_two_type   = 2'b11
  } buf_state_type;
  // handshake and status pins sampled together
  typedef struct packed {
    logic status_a;
    logic aux_a;
    logic strobe_b;
    logic hs_b;
  } pins_type;
endpackage : port16_pkg

// ==== design/port16_unidir.sv ====
// sixteen-bit unidirectional port with strobe/handshake pair and apb registers
//
// Notes on behaviour
// RULE1: ports a and b form one 16-bit port
// RULE2: submode x0 input buffered, x1 output buffered
// RULE3: transfers run only with pair_b_enable set
// RULE4: pair a pins are status/output only
// RULE5: direction bits drive pins and steer reads
// RULE6: x0 writes go straight to output latch
// RULE7: x1 holds byte a until byte b
// RULE8: dma request follows strobe_in_b function only
// RULE9: port b data access advances everything
// RULE10: port a control field layout
// RULE11: control registers read without side effect
// RULE12: reset clears both control registers
// RULE13: software keeps submode while pair enabled
// RULE14: port b control field layout
// RULE15: x0 strobe captures pins, status_b3 flags data
// RULE16: x0 dma request drains input buffers
// RULE17: edge input sets status_b4, cleared variously
// RULE18: level output keeps status_b4 clear
// RULE19: interlocked handshake follows latch room
// RULE20: pulsed handshake lasts at most four cycles
// RULE21: disabled pair holds handshake negated
// RULE22: x0 output writes touch nothing else (a port b write also withdraws dma_request_o for one cycle)
// RULE23: aux_pin_a edge sets status_a2
// RULE24: handshake_out_b control code meanings
// RULE25: aux_pin_a control code meanings
// RULE26: pin edges are synchronised first
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "port16_consts.svh"

module port16_unidir #(
  parameter int PULSE_LEN = `PULSE_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [4:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // parallel data pins
  input  wire logic [15:0] port_in_i,
  output logic      [15:0] port_out_o,
  output logic      [15:0] port_oe_o,
  // handshake and status pins
  input  wire logic        status_pin_a_in_i,
  input  wire logic        aux_pin_a_i,
  output logic             aux_pin_a_o,
  output logic             aux_pin_a_oe_o,
  input  wire logic        strobe_in_b_i,
  input  wire logic        handshake_out_b_i,
  output logic             handshake_out_b_o,
  output logic             handshake_out_b_oe_o,
  output logic             dma_request_o
);

  generate
    if (PULSE_LEN < 1 || PULSE_LEN > 15) begin : g_bad_pulse
      $error("PULSE_LEN must lie between 1 and 15");
    end
  endgenerate

  localparam logic [3:0] PULSE_INIT = 4'(PULSE_LEN);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // per bit: driven pins show the output latch, others the alternate source
  function automatic logic [7:0] rd_mux(input logic [7:0] dir, input logic [7:0] final_output_latch,
                                        input logic [7:0] alt);
    rd_mux = (dir & final_output_latch) | (~dir & alt);
  endfunction : rd_mux

  // one sticky flag: set wins over a write-one clear
  function automatic logic flag_next(input logic cur, input logic set, input logic clr,
                                     input logic keep);
    flag_next = keep & ((cur & ~clr) | set);
  endfunction : flag_next

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  a_ctrl_r;
  logic [7:0]  b_ctrl_r;
  logic [1:0]  gen_ctrl_r;
  logic [15:0] dir_r;
  logic [7:0]  tmp_a_r;
  logic [15:0] fol_r;
  logic [15:0] iol_r;
  logic [15:0] fil_r;
  logic [15:0] iil_r;
  logic [15:0] fol_nxt;
  logic [15:0] iol_nxt;
  logic [15:0] fil_nxt;
  logic [15:0] iil_nxt;
  port16_pkg::buf_state_type in_cnt_r;
  port16_pkg::buf_state_type in_cnt_nxt;
  port16_pkg::buf_state_type out_cnt_r;
  port16_pkg::buf_state_type out_cnt_nxt;
  logic [1:0]  age_r;
  logic [1:0]  age_nxt;
  logic        st_a1_r;
  logic        st_a2_r;
  logic        st_b4_r;
  logic        served_r;
  logic [3:0]  pulse_r;
  port16_pkg::pins_type pin_s1_r;
  port16_pkg::pins_type pin_s2_r;
  port16_pkg::pins_type pin_s3_r;
  logic [15:0] port_d1_r;
  logic [15:0] port_d2_r;

  // decoded control
  logic       sub_x1;
  logic       en_a;
  logic       en_b;
  logic [2:0] hb_code;
  logic [2:0] aux_code;
  logic       hb_edge_mode;
  logic       hb_level_mode;
  logic       hb_hs_mode;
  logic       hb_pulsed;

  assign sub_x1        = b_ctrl_r[`SUB_BIT];                 // see RULE1 see RULE2
  assign en_a          = gen_ctrl_r[`GEN_A_EN_BIT];
  assign en_b          = gen_ctrl_r[`GEN_B_EN_BIT];
  assign hb_code       = b_ctrl_r[`CODE_HI:`CODE_LO];
  assign aux_code      = a_ctrl_r[`CODE_HI:`CODE_LO];
  assign hb_edge_mode  = ~hb_code[2];                        // see RULE24
  assign hb_level_mode = hb_code[2] & ~hb_code[1];
  assign hb_hs_mode    = hb_code[2] & hb_code[1];
  assign hb_pulsed     = hb_hs_mode & hb_code[0];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  // stage one is read only by stage two; edges come from stages two and three
  always_ff @(posedge sys_clk_i) begin
    pin_s1_r  <= '{status_a: status_pin_a_in_i, aux_a: aux_pin_a_i,
                   strobe_b: strobe_in_b_i, hs_b: handshake_out_b_i};
    pin_s2_r  <= pin_s1_r;                                   // see RULE26
    pin_s3_r  <= pin_s2_r;
    port_d1_r <= port_in_i;                                  // data delayed to match strobe
    port_d2_r <= port_d1_r;
  end

  logic edge_a1;
  logic edge_a2;
  logic edge_b3;
  logic edge_b4;
  assign edge_a1 = pin_s2_r.status_a & ~pin_s3_r.status_a;
  assign edge_a2 = pin_s2_r.aux_a & ~pin_s3_r.aux_a;
  assign edge_b3 = pin_s2_r.strobe_b & ~pin_s3_r.strobe_b;
  assign edge_b4 = pin_s2_r.hs_b & ~pin_s3_r.hs_b;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic acc;
  logic wr;
  logic rd;
  logic hit;
  assign acc = psel_i & penable_i & pready_o;                // the edge that completes
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;
  assign hit = (paddr_i == `OFS_A_CTRL) || (paddr_i == `OFS_B_CTRL) ||
               (paddr_i == `OFS_GEN_CTRL) || (paddr_i == `OFS_STATUS) ||
               (paddr_i == `OFS_DIR) || (paddr_i == `OFS_DATA_A) ||
               (paddr_i == `OFS_DATA_B);

  logic wr_b;
  logic acc_b;
  logic wr_st;
  assign wr_b  = wr & (paddr_i == `OFS_DATA_B);
  assign acc_b = acc & (paddr_i == `OFS_DATA_B);             // see RULE9
  assign wr_st = wr & (paddr_i == `OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // handshake request and strobe acceptance

  logic hs_req;
  logic accept;
  // x0 offers room for input, x1 offers held output after a short settle
  assign hs_req = en_b & (sub_x1 ? (out_cnt_r != port16_pkg::buf_empty_type) &&
                                   (age_r == `OUT_DELAY)
                                 : (in_cnt_r != port16_pkg::buf_two_type)); // see RULE19
  // strobes are ignored while no handshake is offered
  assign accept = edge_b3 & hs_req &
                  (~hb_hs_mode | (hb_pulsed ? served_r : handshake_out_b_o)); // see RULE3

  ////////////////////////////////////////////////////////////////////////////
  // input double buffer (submode x0)

  // drain on port b read first, then a capture fills the freed slot
  always_comb begin
    fil_nxt    = fil_r;
    iil_nxt    = iil_r;
    in_cnt_nxt = in_cnt_r;
    if (rd & acc_b & ~sub_x1) begin                          // see RULE16
      case (in_cnt_r)
        port16_pkg::buf_two_type: begin
          fil_nxt    = iil_r;
          in_cnt_nxt = port16_pkg::buf_one_type;
        end
        port16_pkg::buf_one_type: in_cnt_nxt = port16_pkg::buf_empty_type;
        default: in_cnt_nxt = in_cnt_r;
      endcase
    end
    if (accept & ~sub_x1) begin                              // see RULE15
      case (in_cnt_nxt)
        port16_pkg::buf_empty_type: begin
          fil_nxt    = port_d2_r;
          in_cnt_nxt = port16_pkg::buf_one_type;
        end
        port16_pkg::buf_one_type: begin
          iil_nxt    = port_d2_r;
          in_cnt_nxt = port16_pkg::buf_two_type;
        end
        default: in_cnt_nxt = in_cnt_nxt;
      endcase
    end
    if (~en_b | sub_x1) begin
      in_cnt_nxt = port16_pkg::buf_empty_type;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latches (x0 single, x1 double)

  always_comb begin
    fol_nxt     = fol_r;
    iol_nxt     = iol_r;
    out_cnt_nxt = out_cnt_r;
    age_nxt     = (age_r == `OUT_DELAY) ? age_r : age_r + 2'h1;
    if (~sub_x1) begin
      // single latch, no handshake or status effect
      if (wr & (paddr_i == `OFS_DATA_A)) fol_nxt[15:8] = pwdata_i[7:0];  // see RULE6
      if (wr_b) fol_nxt[7:0] = pwdata_i[7:0];                           // see RULE22
      out_cnt_nxt = port16_pkg::buf_empty_type;
    end else begin
      if (accept) begin
        case (out_cnt_r)
          port16_pkg::buf_two_type: begin
            fol_nxt     = iol_r;
            out_cnt_nxt = port16_pkg::buf_one_type;
            age_nxt     = 2'h0;
          end
          port16_pkg::buf_one_type: out_cnt_nxt = port16_pkg::buf_empty_type;
          default: out_cnt_nxt = out_cnt_r;
        endcase
      end
      if (wr_b) begin                                        // see RULE7
        case (out_cnt_nxt)
          port16_pkg::buf_empty_type: begin
            fol_nxt     = {tmp_a_r, pwdata_i[7:0]};
            out_cnt_nxt = port16_pkg::buf_one_type;
            age_nxt     = 2'h0;
          end
          port16_pkg::buf_one_type: begin
            iol_nxt     = {tmp_a_r, pwdata_i[7:0]};
            out_cnt_nxt = port16_pkg::buf_two_type;
          end
          default: iol_nxt = {tmp_a_r, pwdata_i[7:0]};       // full: newest word wins
        endcase
      end
    end
  end

  // data path state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fol_r     <= `WORD_RESET;
      iol_r     <= `WORD_RESET;
      fil_r     <= `WORD_RESET;
      iil_r     <= `WORD_RESET;
      in_cnt_r  <= port16_pkg::buf_empty_type;
      out_cnt_r <= port16_pkg::buf_empty_type;
      age_r     <= 2'h0;
      tmp_a_r   <= 8'h00;
    end else begin
      fol_r     <= fol_nxt;
      iol_r     <= iol_nxt;
      fil_r     <= fil_nxt;
      iil_r     <= iil_nxt;
      in_cnt_r  <= in_cnt_nxt;
      out_cnt_r <= out_cnt_nxt;
      age_r     <= age_nxt;
      if (wr & (paddr_i == `OFS_DATA_A) & sub_x1) tmp_a_r <= pwdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // reads never change these; a submode change while enabled is the user's risk
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      a_ctrl_r   <= `CTRL_RESET;                             // see RULE12
      b_ctrl_r   <= `CTRL_RESET;
      gen_ctrl_r <= 2'h0;
      dir_r      <= `WORD_RESET;
    end else if (wr) begin
      if (paddr_i == `OFS_A_CTRL) a_ctrl_r <= pwdata_i[7:0];      // see RULE10 see RULE11
      if (paddr_i == `OFS_B_CTRL) b_ctrl_r <= pwdata_i[7:0];      // see RULE14
      if (paddr_i == `OFS_GEN_CTRL) gen_ctrl_r <= pwdata_i[1:0];
      if (paddr_i == `OFS_DIR) dir_r <= pwdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_a1_r <= 1'b0;
      st_a2_r <= 1'b0;
      st_b4_r <= 1'b0;
    end else begin
      st_a1_r <= flag_next(st_a1_r, edge_a1, wr_st & pwdata_i[`ST_A1_BIT], en_a); // see RULE4
      st_a2_r <= flag_next(st_a2_r, edge_a2, wr_st & pwdata_i[`ST_A2_BIT],
                           en_a & ~aux_code[2]);             // see RULE23 see RULE25
      st_b4_r <= flag_next(st_b4_r, edge_b4, wr_st & pwdata_i[`ST_B4_BIT],
                           en_b & hb_edge_mode);             // see RULE17 see RULE18
    end
  end

  logic st_b3;
  // x0 flags data present; x1 flags room or emptiness per status control
  assign st_b3 = en_b & (~sub_x1 ? (in_cnt_r != port16_pkg::buf_empty_type) :
                 b_ctrl_r[`STC_BIT] ? (out_cnt_r == port16_pkg::buf_empty_type) :
                                      (out_cnt_r != port16_pkg::buf_two_type));

  ////////////////////////////////////////////////////////////////////////////
  // handshake output

  // pulse counter restarts each time a new offer opens
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      served_r <= 1'b0;
      pulse_r  <= 4'h0;
    end else if (~hs_req | accept | ~hb_pulsed) begin
      served_r <= 1'b0;
      pulse_r  <= 4'h0;                                      // see RULE20
    end else if (~served_r) begin
      served_r <= 1'b1;
      pulse_r  <= PULSE_INIT;
    end else if (pulse_r != 4'h0) begin
      pulse_r  <= pulse_r - 4'h1;
    end
  end

  logic hs_level;
  always_comb begin
    case ({hb_hs_mode, hb_pulsed})
      2'b10:   hs_level = hs_req & ~accept;                  // see RULE19
      2'b11:   hs_level = served_r & (pulse_r > 4'h1) & ~accept;
      default: hs_level = hb_level_mode & hb_code[0];        // see RULE18
    endcase
    if (hb_hs_mode & ~en_b) hs_level = 1'b0;                 // see RULE21
  end

  // pin drivers, all registered
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      handshake_out_b_o    <= 1'b0;
      handshake_out_b_oe_o <= 1'b0;
      aux_pin_a_o          <= 1'b0;
      aux_pin_a_oe_o       <= 1'b0;
      port_out_o           <= `WORD_RESET;
      port_oe_o            <= `WORD_RESET;
      dma_request_o        <= 1'b0;
    end else begin
      handshake_out_b_o    <= hs_level;
      handshake_out_b_oe_o <= ~hb_edge_mode;
      aux_pin_a_o          <= aux_code[2] & aux_code[0];     // see RULE25
      aux_pin_a_oe_o       <= aux_code[2];                   // see RULE4
      port_out_o           <= fol_nxt;
      port_oe_o            <= dir_r;                         // see RULE5
      // request tied to strobe path status only; withdrawn for one cycle on any port b data read or write
      dma_request_o        <= b_ctrl_r[`SVC_BIT] & st_b3 & ~acc_b; // see RULE8 see RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, data taken at the completing edge

  logic [7:0] alt_a;
  logic [7:0] alt_b;
  assign alt_a = sub_x1 ? port_d2_r[15:8] : fil_r[15:8];
  assign alt_b = sub_x1 ? port_d2_r[7:0] : fil_r[7:0];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
      prdata_o  <= 32'h0000_0000;
      if (psel_i & penable_i & ~pready_o & ~pwrite_i) begin
        case (paddr_i)
          `OFS_A_CTRL:   prdata_o <= {24'h000000, a_ctrl_r};
          `OFS_B_CTRL:   prdata_o <= {24'h000000, b_ctrl_r};
          `OFS_GEN_CTRL: prdata_o <= {30'h00000000, gen_ctrl_r};
          `OFS_STATUS:   prdata_o <= {28'h0000000, st_b4_r, st_b3, st_a2_r, st_a1_r};
          `OFS_DIR:      prdata_o <= {16'h0000, dir_r};
          `OFS_DATA_A:   prdata_o <= {24'h000000, rd_mux(dir_r[15:8], fol_r[15:8], alt_a)};
          `OFS_DATA_B:   prdata_o <= {24'h000000, rd_mux(dir_r[7:0], fol_r[7:0], alt_b)};
          default:       prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : port16_unidir

// ==== test/port16_unidir_assertions.sv ====
// concurrent checks on the pins and register bus of the sixteen-bit port
`timescale 1ns/10ps
`include "port16_consts.svh"
module port16_unidir_assertions #(
  parameter int PULSE_LEN = 4
) (
  // clock, reset and bus
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [4:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  // pins
  input wire logic [15:0] port_oe_o,
  input wire logic        aux_pin_a_o,
  input wire logic        aux_pin_a_oe_o,
  input wire logic        handshake_out_b_o,
  input wire logic        handshake_out_b_oe_o,
  input wire logic        dma_request_o
);
  logic [7:0]  ca_r, cb_r;
  logic [1:0]  gen_r;
  logic [15:0] dir_r;
  logic [3:0]  age_r, hi_r;
  wire         wr = psel_i & penable_i & pready_o & pwrite_i;
  wire         rd = psel_i & penable_i & pready_o & ~pwrite_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // shadow copies of what software last wrote
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ca_r  <= 8'h00;
      cb_r  <= 8'h00;
      gen_r <= 2'h0;
      dir_r <= 16'h0000;
    end else if (wr) begin
      if (paddr_i == `OFS_A_CTRL) ca_r <= pwdata_i[7:0];
      if (paddr_i == `OFS_B_CTRL) cb_r <= pwdata_i[7:0];
      if (paddr_i == `OFS_GEN_CTRL) gen_r <= pwdata_i[1:0];
      if (paddr_i == `OFS_DIR) dir_r <= pwdata_i[15:0];
    end
  end
  // settle time since any write; saturates so it never wraps
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || wr) age_r <= 4'h0;
    else if (age_r != 4'hF) age_r <= age_r + 4'h1;
  end
  // run length of a high handshake output
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || wr || !handshake_out_b_o) hi_r <= 4'h0;
    else if (hi_r != 4'hF) hi_r <= hi_r + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_reset_clear: assert property ($fell(rst_i) |-> port_oe_o == 16'h0000
    && !handshake_out_b_o && !dma_request_o && !aux_pin_a_oe_o) else $error("outputs after reset");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_ctrl_read: assert property (rd && paddr_i inside {`OFS_A_CTRL, `OFS_B_CTRL}
    |-> prdata_o[7:0] == ((paddr_i == `OFS_A_CTRL) ? ca_r : cb_r)) else $error("ctrl read");
  chk_oe_dir: assert property (age_r == 4'h3 |-> port_oe_o == dir_r)
    else $error("output enables differ from direction");
  chk_hs_off: assert property (cb_r[5:4] == 2'h3 && !gen_r[1] && age_r > 4'h2
    |-> !handshake_out_b_o) else $error("handshake offered while pair disabled");
  chk_hs_level: assert property (cb_r[5:4] == 2'h2 && gen_r[1] && age_r > 4'h2
    |-> handshake_out_b_oe_o && handshake_out_b_o == cb_r[3]) else $error("hs level");
  chk_hs_input: assert property (!cb_r[5] && age_r > 4'h2 |-> !handshake_out_b_oe_o)
    else $error("handshake driven in input code");
  chk_aux_level: assert property (gen_r[0] && age_r > 4'h2 |-> aux_pin_a_oe_o == ca_r[5]
    && (!ca_r[5] || aux_pin_a_o == ca_r[3])) else $error("aux pin level");
  chk_pulse_len: assert property (cb_r[5:3] == 3'h7 && handshake_out_b_o
    |-> hi_r < PULSE_LEN) else $error("handshake pulse too long");
  chk_dma_gate: assert property (dma_request_o |-> cb_r[1] || $past(cb_r[1]))
    else $error("dma request without service enable");
  // main scenarios reached
  cover property (dma_request_o);
  cover property (cb_r[5:3] == 3'h7 && handshake_out_b_o);
  cover property (aux_pin_a_oe_o && aux_pin_a_o);
endmodule : port16_unidir_assertions

bind port16_unidir port16_unidir_assertions #(.PULSE_LEN(PULSE_LEN)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .port_oe_o(port_oe_o), .aux_pin_a_o(aux_pin_a_o),
  .aux_pin_a_oe_o(aux_pin_a_oe_o), .handshake_out_b_o(handshake_out_b_o),
  .handshake_out_b_oe_o(handshake_out_b_oe_o), .dma_request_o(dma_request_o)
);

// ==== test/periph_model.sv ====
// external peripheral that strobes words into the port
`timescale 1ns/10ps
module periph_model (
  // clock and handshake seen from the port
  input  wire logic        sys_clk_i,
  input  wire logic        hs_i,
  // word request from the bench
  input  wire logic        send_i,
  input  wire logic [15:0] word_i,
  input  wire logic [3:0]  slow_i,
  // pins toward the port
  output logic      [15:0] data_o,
  output logic             strobe_o
);
  logic [15:0] w;
  logic        seen = 1'h0;
  // offers last until the next strobe
  always @(posedge sys_clk_i) seen <= !strobe_o && (seen || hs_i === 1'h1);
  initial begin
    data_o   = 16'hA5A5;
    strobe_o = 1'h0;
  end
  // one word per request; data released to its inverse
  always begin
    @(posedge sys_clk_i);
    if (send_i) begin
      w = word_i;
      repeat (slow_i) @(posedge sys_clk_i);
      while (!seen) @(posedge sys_clk_i);
      data_o   <= w;
      strobe_o <= 1'h1;
      repeat (4) @(posedge sys_clk_i);
      strobe_o <= 1'h0;
      data_o   <= ~w;
      repeat (3) @(posedge sys_clk_i); // synchroniser spacing
    end
  end
endmodule : periph_model

// ==== test/tb_top.sv ====
// self-checking bench for the sixteen-bit handshake port
`timescale 1ns/10ps
`include "port16_consts.svh"
module tb_top;
  logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic        pready, pslverr, st_a = 1'h0, aux_tb = 1'h0, hs_tb = 1'h0, strb;
  logic        aux_o, aux_oe, hs_o, hs_oe, dma, snd = 1'h0;
  logic [4:0]  paddr = 5'h00, ad;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] pout, poe, per_d, wd = 16'h0000, w1, w2;
  logic [3:0]  sl = 4'h0;
  logic [32:0] q[$];
  int          n_errors = 0, n_tests = 0, seed = 88, cyc_n = 0;
  // pins resolve between the port's drivers and the outside
  wire  [15:0] pin = (poe & pout) | (~poe & per_d);
  wire         aux_w = aux_oe ? aux_o : aux_tb;
  wire         hs_w = hs_oe ? hs_o : hs_tb;
  always #5 clk = ~clk;
  port16_unidir u_port16_unidir (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .port_in_i(pin), .port_out_o(pout), .port_oe_o(poe),
    .status_pin_a_in_i(st_a), .aux_pin_a_i(aux_w), .aux_pin_a_o(aux_o), .aux_pin_a_oe_o(aux_oe),
    .strobe_in_b_i(strb), .handshake_out_b_i(hs_w), .handshake_out_b_o(hs_o),
    .handshake_out_b_oe_o(hs_oe), .dma_request_o(dma));
  periph_model u_periph_model (.sys_clk_i(clk), .hs_i(hs_o), .send_i(snd), .word_i(wd),
    .slow_i(sl), .data_o(per_d), .strobe_o(strb));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one bus transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 40);
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask : apb
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic err);
    q.push_back({err, e});
    apb(1'h0, a, 32'h0);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic send(input logic [15:0] w, input logic [3:0] s);
    @(posedge clk);
    snd <= 1'h1;
    wd  <= w;
    sl  <= s;
    @(posedge clk);
    snd <= 1'h0;
    cyc(30);
  endtask : send
  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // reads checked against the oldest expectation
  always @(posedge clk) begin
    if (psel && pen && pready === 1'h1 && !pwr)
      chk("prdata", q.pop_front(), {pslverr, prdata});
  end
  // hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rd(`OFS_A_CTRL, 32'h0, 1'h0);
    rd(`OFS_B_CTRL, 32'h0, 1'h0);
    chk("oe", 16'h0000, poe);
    // random control round trip, each read twice
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      ad = i[0] ? `OFS_B_CTRL : `OFS_A_CTRL;
      wr(ad, r);
      rd(ad, {24'h0, r[7:0]}, 1'h0);
      rd(ad, {24'h0, r[7:0]}, 1'h0);
    end
    rd(5'h1C, 32'h0, 1'h1);
    wr(`OFS_A_CTRL, 32'h0);
    wr(`OFS_B_CTRL, 32'h0);
    // submode x0 single-buffered output
    r = $random(seed);
    wr(`OFS_DIR, {16'h0, r[15:0]});
    cyc(3);
    chk("oe", r[15:0], poe);
    wr(`OFS_DATA_A, 32'h5A);
    wr(`OFS_DATA_B, 32'hC3);
    cyc(3);
    chk("out", 16'h5AC3, pout);
    wr(`OFS_DIR, 32'hFFFF);
    rd(`OFS_DATA_A, 32'h5A, 1'h0);
    rd(`OFS_STATUS, 32'h0, 1'h0);
    // pair a level outputs, then edge flags and their clearing
    wr(`OFS_GEN_CTRL, 32'h1);
    for (int c = 4; c < 8; c++) begin
      wr(`OFS_A_CTRL, c << 3);
      cyc(3);
      chk("aux", {1'h1, c[0]}, {aux_oe, aux_o});
    end
    wr(`OFS_A_CTRL, 32'h0);
    cyc(4);
    st_a   <= 1'h1;
    aux_tb <= 1'h1;
    cyc(4);
    st_a   <= 1'h0;
    aux_tb <= 1'h0;
    cyc(4);
    rd(`OFS_STATUS, 32'h3, 1'h0);
    wr(`OFS_STATUS, 32'h3);
    rd(`OFS_STATUS, 32'h0, 1'h0);
    // handshake pin as level output and as edge input
    wr(`OFS_GEN_CTRL, 32'h2);
    for (int c = 4; c < 6; c++) begin
      wr(`OFS_B_CTRL, c << 3);
      cyc(3);
      chk("hs", {1'h1, c[0]}, {hs_oe, hs_o});
    end
    wr(`OFS_B_CTRL, 32'h0);
    cyc(4);
    hs_tb <= 1'h1;
    cyc(4);
    hs_tb <= 1'h0;
    cyc(4);
    rd(`OFS_STATUS, 32'h8, 1'h0);
    wr(`OFS_STATUS, 32'h8);
    wr(`OFS_DIR, 32'h0);
    // double-buffered input, interlocked then pulsed
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_GEN_CTRL, 32'h0);
      wr(`OFS_B_CTRL, m ? 32'h3A : 32'h32);
      cyc(3);
      chk("hs", 2'h2, {hs_oe, hs_o});
      wr(`OFS_GEN_CTRL, 32'h2);
      w1 = $random(seed);
      w2 = $random(seed);
      send(w1, m ? 4'h0 : 4'h5);
      send(w2, 4'h0);
      chk("full", 2'h1, {hs_o, dma});
      rd(`OFS_STATUS, 32'h4, 1'h0);
      rd(`OFS_DATA_A, {24'h0, w1[15:8]}, 1'h0);
      rd(`OFS_DATA_B, {24'h0, w1[7:0]}, 1'h0);
      rd(`OFS_DATA_A, {24'h0, w2[15:8]}, 1'h0);
      rd(`OFS_DATA_B, {24'h0, w2[7:0]}, 1'h0);
      cyc(3);
      chk("dma", 1'h0, dma);
    end
    // submode x1: byte a waits for byte b, second word waits for a strobe
    wr(`OFS_GEN_CTRL, 32'h0);
    wr(`OFS_B_CTRL, 32'h72);
    wr(`OFS_DIR, 32'hFFFF);
    wr(`OFS_GEN_CTRL, 32'h2);
    wr(`OFS_DATA_A, 32'h12);
    wr(`OFS_DATA_B, 32'h34);
    cyc(4);
    chk("out", 16'h1234, pout);
    wr(`OFS_DATA_A, 32'h56);
    wr(`OFS_DATA_B, 32'h78);
    cyc(3);
    chk("out", 16'h1234, pout);
    send(16'h0000, 4'h0);
    chk("out", 16'h5678, pout);
    stop_test();
  end
endmodule : tb_top
